// ==== verilog/fpe_defines.svh ====
// Purpose: constants for the frequency protection element
// Assumes: 25 MHz system clock, 24-bit period counts
// Notes:   settings are plain ports; no register map
`ifndef FPE_DEFINES_SVH
`define FPE_DEFINES_SVH

`define FPE_NUM_ELEMENTS    6
`define FPE_NUM_PHASES      3
`define FPE_CLK_HZ          25000000
`define FPE_PER_W           24
`define FPE_AMP_W           16
// Minimum-voltage inhibit as a fraction of nominal, in 1/100 units
`define FPE_MIN_VOLT_PCT    15
`define FPE_PCT_DEN         100
// Period count above which a phase is considered lost (about 10 Hz)
`define FPE_PER_MAX_HZ      10
`define FPE_PER_MAX         (`FPE_CLK_HZ / `FPE_PER_MAX_HZ)
// Successive same-sign gradient samples needed to accept a gradient
`define FPE_GRAD_CONFIRM    3
`define FPE_DELAY_W         32
// Default undervoltage block setting: 15 percent of nominal
`define FPE_UV_PCT_RESET    8'h0F

`endif

// ==== verilog/fpe_pkg.sv ====
// Purpose: types for the frequency protection element
// Assumes: nothing beyond the defines header
// Notes:   mode encodings are stable
package fpe_pkg;

    typedef enum logic [2:0]
    {
        FPE_MODE_UNDER      = 3'h0,
        FPE_MODE_OVER       = 3'h1,
        FPE_MODE_ROC        = 3'h2,
        FPE_MODE_UNDER_ROC  = 3'h3,
        FPE_MODE_OVER_ROC   = 3'h4,
        FPE_MODE_UNDER_CPI  = 3'h5,
        FPE_MODE_OVER_CPI   = 3'h6,
        FPE_MODE_SURGE      = 3'h7
    } fpe_mode_t;

    typedef enum logic [1:0]
    {
        FPE_GRAD_POS = 2'h0,
        FPE_GRAD_NEG = 2'h1,
        FPE_GRAD_ABS = 2'h2
    } fpe_grad_t;

    typedef enum logic [2:0]
    {
        FPE_ST_IDLE  = 3'b001,
        FPE_ST_ALARM = 3'b010,
        FPE_ST_TRIP  = 3'b100
    } fpe_state_t;

endpackage

// ==== verilog/fpe_element.sv ====
// Purpose: one supervision element: pickup, delay timer, alarm, trip
// Assumes: frequency and gradient updated by the caller each evaluation
// Notes:   change-per-interval and surge modes never pick up here
`timescale 1ns/1ps
`include "fpe_defines.svh"
module fpe_element
    import fpe_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     arst_n,
    input  wire logic                     block,
    input  wire logic                     meas_valid,
    input  wire logic [`FPE_PER_W-1:0]    period,
    input  wire logic signed [`FPE_PER_W:0] grad,
    input  wire logic                     grad_ok,
    input  wire fpe_mode_t                mode,
    input  wire fpe_grad_t                grad_mode,
    input  wire logic [`FPE_PER_W-1:0]    pickup_period,
    input  wire logic [`FPE_PER_W-1:0]    grad_thresh,
    input  wire logic [`FPE_DELAY_W-1:0]  delay_cycles,
    output logic                          alarm,
    output logic                          trip
);

    fpe_state_t               state_reg;
    fpe_state_t               state_next;
    logic [`FPE_DELAY_W-1:0]  timer_reg;
    logic [`FPE_DELAY_W-1:0]  timer_next;
    logic                     under_f;
    logic                     over_f;
    logic                     roc_hit;
    logic                     pick;
    logic signed [`FPE_PER_W:0] thr_s;

    // Periods are compared, so lower frequency means a longer period
    assign under_f = period > pickup_period;
    assign over_f  = period < pickup_period;
    assign thr_s   = {1'b0, grad_thresh};

    always_comb
    begin
        case (grad_mode)
            FPE_GRAD_POS: roc_hit = grad_ok && grad > thr_s;
            FPE_GRAD_NEG: roc_hit = grad_ok && grad < -thr_s;
            FPE_GRAD_ABS: roc_hit = grad_ok && (grad > thr_s || grad < -thr_s);
            default:      roc_hit = 1'b0;
        endcase
        case (mode)
            FPE_MODE_UNDER:     pick = under_f;
            FPE_MODE_OVER:      pick = over_f;
            FPE_MODE_ROC:       pick = roc_hit;
            FPE_MODE_UNDER_ROC: pick = under_f && roc_hit;
            FPE_MODE_OVER_ROC:  pick = over_f && roc_hit;
            default:            pick = 1'b0;
        endcase
        pick = pick && meas_valid && !block;
    end

    always_comb
    begin
        state_next = state_reg;
        timer_next = timer_reg;
        // block forces idle and clears the timer
        if (!pick)
        begin
            state_next = FPE_ST_IDLE;
            timer_next = '0;
        end
        else
        begin
            case (state_reg)
                FPE_ST_IDLE:
                begin
                    state_next = FPE_ST_ALARM;
                    timer_next = '0;
                end
                FPE_ST_ALARM:
                begin
                    if (timer_reg >= delay_cycles)
                        state_next = FPE_ST_TRIP;
                    else
                        timer_next = timer_reg + 1'b1;
                end
                FPE_ST_TRIP:
                    state_next = FPE_ST_TRIP;
                default:
                    state_next = FPE_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= FPE_ST_IDLE;
            timer_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= timer_next;
        end
    end

    // Alarm follows pickup in the same cycle, no added delay
    assign alarm = pick;
    assign trip  = pick && state_reg == FPE_ST_TRIP;

endmodule

// ==== verilog/fpe_frequency_protection.sv ====
// Purpose: frequency supervision with six elements on three phases
// Assumes: signed voltage samples synchronous to sys_clk
// Notes:   frequency is carried as an averaged period in clock cycles
//
// What this block does
// - Six identical, independently configured frequency elements.
// - Supervised frequency is the mean of valid phase results.
// - Lost phases leave the average; divide by remaining count.
// - Each phase period is timed between zero crossings.
// - All supervision inhibited when all phases are below 0.15 of nominal voltage.
// - Calculation blocked when all phases under undervoltage setting.
// - Each element selects one of eight modes; the CPI and surge modes never pick up.
// - Under-frequency alarm asserts immediately below pickup.
// - Under-frequency trip only after staying below for full delay.
// - Over-frequency alarm asserts immediately above pickup.
// - Over-frequency trip only after staying above for full delay.
// - Pickup on the averaged period, only when not blocked; starts timer.
// - Gradient computed at each rising crossing of any phase.
// - Gradient accepted only after consistent sign over several samples.
// - Gradient signed: positive rising, negative falling.
// - Gradient mode: positive, negative or absolute detection.
// - Rate-of-change alarm immediate when gradient beyond threshold.
// - Rate-of-change trip only after full delay beyond threshold.
`timescale 1ns/1ps
`include "fpe_defines.svh"
module fpe_frequency_protection
    import fpe_pkg::*;
(
    input  wire logic                           sys_clk,
    input  wire logic                           arst_n,
    input  wire logic                           sample_en,
    input  wire logic signed [`FPE_AMP_W-1:0]   phase_v0,
    input  wire logic signed [`FPE_AMP_W-1:0]   phase_v1,
    input  wire logic signed [`FPE_AMP_W-1:0]   phase_v2,
    input  wire logic [`FPE_AMP_W-1:0]          nominal_voltage,
    input  wire logic [7:0]                     uv_block_pct,
    input  wire logic [`FPE_NUM_ELEMENTS-1:0]   ext_block,
    input  wire fpe_mode_t                      mode0,
    input  wire fpe_mode_t                      mode1,
    input  wire fpe_mode_t                      mode2,
    input  wire fpe_mode_t                      mode3,
    input  wire fpe_mode_t                      mode4,
    input  wire fpe_mode_t                      mode5,
    input  wire logic [11:0]                    grad_mode_all,
    input  wire logic [`FPE_PER_W*6-1:0]        pickup_period_all,
    input  wire logic [`FPE_PER_W*6-1:0]        grad_thresh_all,
    input  wire logic [`FPE_DELAY_W*6-1:0]      delay_cycles_all,
    output logic [`FPE_PER_W-1:0]               avg_period,
    output logic signed [`FPE_PER_W:0]          grad_out,
    output logic                                freq_valid,
    output logic                                uv_blocked,
    output logic [`FPE_NUM_ELEMENTS-1:0]        alarm,
    output logic [`FPE_NUM_ELEMENTS-1:0]        trip
);

    localparam int NP = `FPE_NUM_PHASES;

    logic signed [`FPE_AMP_W-1:0] v        [NP];
    logic [NP-1:0]                pos_reg,   pos_next;
    logic [`FPE_PER_W-1:0]        cnt_reg    [NP];
    logic [`FPE_PER_W-1:0]        cnt_next   [NP];
    logic [`FPE_PER_W-1:0]        per_reg    [NP];
    logic [`FPE_PER_W-1:0]        per_next   [NP];
    logic [NP-1:0]                pval_reg,  pval_next;
    logic [`FPE_AMP_W-1:0]        pk_reg     [NP];
    logic [`FPE_AMP_W-1:0]        pk_next    [NP];
    logic [`FPE_AMP_W-1:0]        amp_reg    [NP];
    logic [`FPE_AMP_W-1:0]        amp_next   [NP];
    logic [`FPE_PER_W-1:0]        avg_next;
    logic [`FPE_PER_W-1:0]        prev_reg,  prev_next;
    logic signed [`FPE_PER_W:0]   grad_reg,  grad_next;
    logic signed [`FPE_PER_W:0]   graw;
    logic [1:0]                   sgn_reg,   sgn_next;
    logic [2:0]                   run_reg,   run_next;
    logic                         fval_next;
    logic                         uv_all;
    logic                         uv_min;
    logic                         upd;
    logic [NP-1:0]                xing;
    logic [`FPE_PER_W+1:0]        sum;
    logic [1:0]                   nval;

    // Absolute value of a sample
    function automatic logic [`FPE_AMP_W-1:0] abs_v(
        input logic signed [`FPE_AMP_W-1:0] x);
        abs_v = x[`FPE_AMP_W-1] ? `FPE_AMP_W'(-x) : `FPE_AMP_W'(x);
    endfunction

    // True when amplitude is below pct percent of nominal
    function automatic logic below_pct(
        input logic [`FPE_AMP_W-1:0] a,
        input logic [7:0]            pct);
        below_pct = (32'(a) * `FPE_PCT_DEN) < (32'(nominal_voltage) * pct);
    endfunction

    assign v[0] = phase_v0;
    assign v[1] = phase_v1;
    assign v[2] = phase_v2;

    always_comb
    begin
        pos_next  = pos_reg;
        pval_next = pval_reg;
        uv_all    = 1'b1;
        uv_min    = 1'b1;
        for (int i = 0; i < NP; i++)
        begin
            cnt_next[i] = cnt_reg[i];
            per_next[i] = per_reg[i];
            pk_next[i]  = pk_reg[i];
            amp_next[i] = amp_reg[i];
            // Rising crossing only, so a whole cycle is timed
            xing[i] = sample_en && !pos_reg[i] && !v[i][`FPE_AMP_W-1];
            if (sample_en)
            begin
                pos_next[i] = !v[i][`FPE_AMP_W-1];
                cnt_next[i] = cnt_reg[i] + 1'b1;
                if (abs_v(v[i]) > pk_reg[i])
                    pk_next[i] = abs_v(v[i]);
            end
            // restart period at each rising zero crossing
            if (xing[i])
            begin
                // Count includes the crossing sample: a whole period
                per_next[i]  = cnt_reg[i] + 1'b1;
                cnt_next[i]  = '0;
                amp_next[i]  = pk_reg[i];
                pk_next[i]   = '0;
                pval_next[i] = 1'b1;
            end
            else if (cnt_reg[i] >= `FPE_PER_W'(`FPE_PER_MAX))
            begin
                pval_next[i] = 1'b0;
                cnt_next[i]  = cnt_reg[i];
                amp_next[i]  = '0;
            end
            if (!below_pct(amp_reg[i], uv_block_pct))
                uv_all = 1'b0;
            if (!below_pct(amp_reg[i], 8'(`FPE_MIN_VOLT_PCT)))
                uv_min = 1'b0;
        end
    end

    always_comb
    begin
        sum  = '0;
        nval = '0;
        for (int i = 0; i < NP; i++)
            if (pval_reg[i])
            begin
                sum  = sum + (`FPE_PER_W+2)'(per_reg[i]);
                nval = nval + 2'h1;
            end
        case (nval)
            2'h1:    avg_next = sum[`FPE_PER_W-1:0];
            2'h2:    avg_next = sum[`FPE_PER_W:1];
            2'h3:    avg_next = `FPE_PER_W'(sum / 3);
            default: avg_next = avg_period;
        endcase
        fval_next = nval != 2'h0 && !uv_all && !uv_min;
        upd       = |xing && fval_next;
        prev_next = prev_reg;
        grad_next = grad_reg;
        sgn_next  = sgn_reg;
        run_next  = run_reg;
        // longer period means falling frequency, negative gradient
        graw = $signed({1'b0, prev_reg}) - $signed({1'b0, avg_next});
        if (upd)
        begin
            prev_next = avg_next;
            grad_next = graw;
            sgn_next  = {graw < 0, graw > 0};
            // count successive samples of equal sign
            if (sgn_next == sgn_reg && sgn_next != 2'h0)
                run_next = (run_reg == 3'h7) ? run_reg : run_reg + 3'h1;
            else
                run_next = 3'h1;
        end
        if (!fval_next)
            run_next = '0;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // Starts positive so leaving reset is not taken as a crossing
            pos_reg    <= '1;
            pval_reg   <= '0;
            avg_period <= '0;
            prev_reg   <= '0;
            grad_reg   <= '0;
            sgn_reg    <= '0;
            run_reg    <= '0;
            freq_valid <= 1'b0;
            for (int i = 0; i < NP; i++)
            begin
                cnt_reg[i] <= '0;
                per_reg[i] <= '0;
                pk_reg[i]  <= '0;
                amp_reg[i] <= '0;
            end
        end
        else
        begin
            pos_reg    <= pos_next;
            pval_reg   <= pval_next;
            avg_period <= avg_next;
            prev_reg   <= prev_next;
            grad_reg   <= grad_next;
            sgn_reg    <= sgn_next;
            run_reg    <= run_next;
            freq_valid <= fval_next;
            for (int i = 0; i < NP; i++)
            begin
                cnt_reg[i] <= cnt_next[i];
                per_reg[i] <= per_next[i];
                pk_reg[i]  <= pk_next[i];
                amp_reg[i] <= amp_next[i];
            end
        end
    end

    assign grad_out   = grad_reg;
    assign uv_blocked = !freq_valid;

    fpe_mode_t modes [`FPE_NUM_ELEMENTS];
    assign modes[0] = mode0;
    assign modes[1] = mode1;
    assign modes[2] = mode2;
    assign modes[3] = mode3;
    assign modes[4] = mode4;
    assign modes[5] = mode5;

    // one element instance per frequency stage
    for (genvar e = 0; e < `FPE_NUM_ELEMENTS; e++)
    begin : g_el
        fpe_element u_el
        (
            .sys_clk       (sys_clk),
            .arst_n        (arst_n),
            .block         (ext_block[e] || !freq_valid),
            .meas_valid    (freq_valid),
            .period        (avg_period),
            .grad          (grad_reg),
            .grad_ok       (run_reg >= 3'(`FPE_GRAD_CONFIRM)),
            .mode          (modes[e]),
            .grad_mode     (fpe_grad_t'(grad_mode_all[2*e +: 2])),
            .pickup_period (pickup_period_all[`FPE_PER_W*e +: `FPE_PER_W]),
            .grad_thresh   (grad_thresh_all[`FPE_PER_W*e +: `FPE_PER_W]),
            .delay_cycles  (delay_cycles_all[`FPE_DELAY_W*e +: `FPE_DELAY_W]),
            .alarm         (alarm[e]),
            .trip          (trip[e])
        );
    end

endmodule

// ==== verification/fpe_checker_asserts.sv ====
// Purpose: port-level checks on the frequency protection block
// Assumes: alarm is combinational from the registered average period
// Notes:   only elements 0, 1 and 5 are tied to their settings here
`timescale 1ns/1ps
`include "fpe_defines.svh"
module fpe_checker_asserts
    import fpe_pkg::*;
(
    input wire logic                         sys_clk,
    input wire logic                         arst_n,
    input wire logic [`FPE_NUM_ELEMENTS-1:0] ext_block,
    input wire fpe_mode_t                    mode0,
    input wire fpe_mode_t                    mode1,
    input wire fpe_mode_t                    mode5,
    input wire logic [`FPE_PER_W*6-1:0]      pickup_period_all,
    input wire logic [`FPE_DELAY_W*6-1:0]    delay_cycles_all,
    input wire logic [`FPE_PER_W-1:0]        avg_period,
    input wire logic                         freq_valid,
    input wire logic                         uv_blocked,
    input wire logic [`FPE_NUM_ELEMENTS-1:0] alarm,
    input wire logic [`FPE_NUM_ELEMENTS-1:0] trip
);
    logic [31:0] run_reg;
    logic [31:0] run_next;

    // Consecutive alarm cycles of element 0; saturates to avoid wrap
    always_comb
    begin
        run_next = alarm[0] ? run_reg + ((&run_reg) ? 32'h0 : 32'h1) : 32'h0;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            run_reg <= 32'h0;
        else
            run_reg <= run_next;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_uv_inverse_valid: assert property (uv_blocked == !freq_valid)
        else $error("uv_blocked is not the inverse of freq_valid");
    a_uv_outputs_off: assert property (
        uv_blocked |-> (alarm == 6'h0 && trip == 6'h0))
        else $error("alarm or trip active while undervoltage blocked");
    a_ext_block_off: assert property (
        (ext_block & (alarm | trip)) == 6'h0)
        else $error("blocked element shows alarm or trip");
    a_trip_needs_alarm: assert property ((trip & ~alarm) == 6'h0)
        else $error("trip without alarm");
    a_under_alarm_now: assert property (mode0 == FPE_MODE_UNDER |->
        alarm[0] == (freq_valid && !ext_block[0]
                     && avg_period > pickup_period_all[23:0]))
        else $error("under-frequency alarm disagrees with period");
    a_over_alarm_now: assert property (mode1 == FPE_MODE_OVER |->
        alarm[1] == (freq_valid && !ext_block[1]
                     && avg_period < pickup_period_all[47:24]))
        else $error("over-frequency alarm disagrees with period");
    a_trip_full_delay: assert property (
        trip[0] |-> run_reg >= delay_cycles_all[31:0])
        else $error("trip before the full delay");
    a_quiet_modes: assert property (
        mode5 inside {FPE_MODE_UNDER_CPI, FPE_MODE_OVER_CPI, FPE_MODE_SURGE}
        |-> !alarm[5] && !trip[5])
        else $error("unsupported mode picked up");
    a_trip_drops: assert property ($fell(alarm[0]) |-> !trip[0])
        else $error("trip stayed after alarm dropped");

    c_alarm_rise: cover property ($rose(alarm[0]));
    c_trip_rise: cover property ($rose(trip[0]));
    c_uv_rise: cover property ($rose(uv_blocked));
endmodule

bind fpe_frequency_protection fpe_checker_asserts u_chk
(
    .sys_clk(sys_clk), .arst_n(arst_n), .ext_block(ext_block),
    .mode0(mode0), .mode1(mode1), .mode5(mode5),
    .pickup_period_all(pickup_period_all),
    .delay_cycles_all(delay_cycles_all), .avg_period(avg_period),
    .freq_valid(freq_valid), .uv_blocked(uv_blocked),
    .alarm(alarm), .trip(trip)
);

// ==== verification/fpe_mains_model.sv ====
// Purpose: three-phase mains model: square waves of settable period
// Assumes: one sample per clock; period in samples per phase
// Notes:   phases stay aligned while their periods match
`timescale 1ns/1ps
module fpe_mains_model
(
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    input  wire logic [15:0]   per0,
    input  wire logic [15:0]   per1,
    input  wire logic [15:0]   per2,
    input  wire logic [15:0]   amp,
    output logic               sample_en,
    output logic signed [15:0] phase_v0,
    output logic signed [15:0] phase_v1,
    output logic signed [15:0] phase_v2
);
    logic [15:0] cnt [3];
    logic [15:0] per [3];

    assign per[0] = per0;
    assign per[1] = per1;
    assign per[2] = per2;
    // Whole cycles: one rising crossing each time the count wraps
    assign phase_v0 = (cnt[0] < per0 / 2) ? $signed(amp) : -$signed(amp);
    assign phase_v1 = (cnt[1] < per1 / 2) ? $signed(amp) : -$signed(amp);
    assign phase_v2 = (cnt[2] < per2 / 2) ? $signed(amp) : -$signed(amp);

    always @(negedge sys_clk or negedge arst_n)
    begin
        sample_en <= arst_n;
        for (int i = 0; i < 3; i++)
            cnt[i] <= (!arst_n || cnt[i] >= per[i] - 16'h1) ? 16'h0
                                                          : cnt[i] + 16'h1;
    end
endmodule

// ==== verification/testbench.sv ====
// Purpose: scenario testbench for the frequency protection block
// Assumes: one sample per clock, so periods are in clock cycles
// Notes:   phase loss after 10 Hz is too long to reach in a short run
`timescale 1ns/1ps
`include "fpe_defines.svh"
module testbench
    import fpe_pkg::*;
;
    logic sys_clk, arst_n, sample_en;
    logic signed [15:0] phase_v0, phase_v1, phase_v2;
    logic [15:0] per0, per1, per2, amp, nominal_voltage;
    logic [7:0] uv_block_pct;
    logic [5:0] ext_block, alarm, trip, seen;
    fpe_mode_t mode0, mode1, mode2, mode3, mode4, mode5;
    logic [11:0] grad_mode_all;
    logic [143:0] pickup_period_all, grad_thresh_all;
    logic [191:0] delay_cycles_all;
    logic [23:0] avg_period;
    logic signed [24:0] grad_out;
    logic freq_valid, uv_blocked, gpos, gneg;
    int mismatches, tests_run;

    fpe_mains_model mains (.sys_clk(sys_clk), .arst_n(arst_n),
        .per0(per0), .per1(per1), .per2(per2), .amp(amp),
        .sample_en(sample_en), .phase_v0(phase_v0),
        .phase_v1(phase_v1), .phase_v2(phase_v2));
    fpe_frequency_protection dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .sample_en(sample_en), .phase_v0(phase_v0), .phase_v1(phase_v1),
        .phase_v2(phase_v2), .nominal_voltage(nominal_voltage),
        .uv_block_pct(uv_block_pct), .ext_block(ext_block),
        .mode0(mode0), .mode1(mode1), .mode2(mode2), .mode3(mode3),
        .mode4(mode4), .mode5(mode5), .grad_mode_all(grad_mode_all),
        .pickup_period_all(pickup_period_all),
        .grad_thresh_all(grad_thresh_all),
        .delay_cycles_all(delay_cycles_all), .avg_period(avg_period),
        .grad_out(grad_out), .freq_valid(freq_valid),
        .uv_blocked(uv_blocked), .alarm(alarm), .trip(trip));

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic complete_run();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [24:0] got, input logic [24:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t value got %0d exp %0d", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic set_pk(input int i, input logic [23:0] pk);
        pickup_period_all[i*24 +: 24] = pk;
    endtask

    // Runs n cycles, gathering alarms and gradient signs seen
    task automatic watch(input int n);
        seen = 6'h0;
        gpos = 1'b0;
        gneg = 1'b0;
        repeat (n)
        begin
            @(negedge sys_clk);
            seen = seen | alarm;
            gpos = gpos | (grad_out > 0);
            gneg = gneg | (grad_out < 0);
        end
    endtask

    task automatic t_reset();
        chk_val({alarm, trip}, 25'h0);
        chk_bit(freq_valid, 1'b0);
    endtask

    task automatic t_under_over();
        cyc(600);
        chk_val(avg_period, 25'd100);
        chk_bit(uv_blocked, 1'b0);
        chk_bit(alarm[0], 1'b1);
        chk_bit(alarm[1], 1'b1);
        chk_bit(trip[0], 1'b1);
        chk_bit(trip[1], 1'b1);
    endtask

    task automatic t_dropout();
        set_pk(0, 24'd120);
        cyc(1);
        chk_bit(alarm[0], 1'b0);
        chk_bit(trip[0], 1'b0);
        set_pk(0, 24'd90);
        cyc(1);
        chk_bit(alarm[0], 1'b1);
        chk_bit(trip[0], 1'b0);
        cyc(10);
        chk_bit(trip[0], 1'b0);
        cyc(15);
        chk_bit(trip[0], 1'b1);
    endtask

    task automatic t_block();
        ext_block = 6'h02;
        cyc(2);
        chk_val({alarm[1], trip[1], alarm[0]}, 25'h1);
        ext_block = 6'h00;
        cyc(2);
        chk_val({alarm[1], trip[1]}, 25'h2);
    endtask

    task automatic t_average();
        per2 = 16'd106;
        cyc(800);
        chk_val(avg_period, 25'd102);
        per2 = 16'd100;
        cyc(600);
        chk_val(avg_period, 25'd100);
    endtask

    task automatic t_undervolt();
        amp = 16'd100;
        cyc(400);
        chk_bit(uv_blocked, 1'b1);
        chk_val({alarm, trip}, 25'h0);
        amp = 16'd140;
        cyc(400);
        chk_bit(freq_valid, 1'b0);
        amp = 16'd1000;
        cyc(600);
        chk_bit(freq_valid, 1'b1);
        chk_bit(alarm[0], 1'b1);
    endtask

    task automatic t_modes();
        mode5 = FPE_MODE_UNDER;
        cyc(2);
        chk_bit(alarm[5], 1'b1);
        for (int m = 5; m < 8; m++)
        begin
            mode5 = fpe_mode_t'(m);
            cyc(300);
            chk_val({alarm[5], trip[5]}, 25'h0);
        end
    endtask

    task automatic t_gradient(input logic fall);
        logic [5:0] acc;
        logic sp, sn;
        acc = 6'h0;
        sp = 1'b0;
        sn = 1'b0;
        // Settle to a zero gradient, then start just after a wrap
        cyc(200);
        for (int w = 0; w < 200 && !phase_v0[15]; w++)
            @(negedge sys_clk);
        chk_bit(phase_v0[15], 1'b1);
        for (int w = 0; w < 200 && phase_v0[15]; w++)
            @(negedge sys_clk);
        chk_bit(phase_v0[15], 1'b0);
        // One new period per mains cycle keeps every gradient sample after the first nonzero
        for (int k = 1; k < 8; k++)
        begin
            per0 = fall ? 16'd100 - 16'(4 * k) : 16'd72 + 16'(4 * k);
            per1 = per0;
            per2 = per0;
            watch(per0);
            acc = acc | seen;
            sp = sp | gpos;
            sn = sn | gneg;
        end
        chk_val({sp, sn}, fall ? 25'h2 : 25'h1);
        chk_val(acc[4:2], fall ? 25'h5 : 25'h6);
    endtask

    initial
    begin
        mismatches = 0;
        tests_run = 0;
        arst_n = 1'b0;
        {per0, per1, per2} = {16'd100, 16'd100, 16'd100};
        amp = 16'd1000;
        nominal_voltage = 16'd1000;
        uv_block_pct = 8'h0F;
        ext_block = 6'h00;
        mode0 = FPE_MODE_UNDER;
        mode1 = FPE_MODE_OVER;
        mode2 = FPE_MODE_ROC;
        mode3 = FPE_MODE_UNDER_ROC;
        mode4 = FPE_MODE_OVER_ROC;
        mode5 = FPE_MODE_UNDER_CPI;
        grad_mode_all = {2'h0, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0};
        pickup_period_all = {6{24'd90}};
        set_pk(1, 24'd110);
        grad_thresh_all = {6{24'd1}};
        delay_cycles_all = {6{32'd20}};
        repeat (5) @(posedge sys_clk);
        t_reset();
        @(negedge sys_clk);
        arst_n = 1'b1;
        t_under_over();
        t_dropout();
        t_block();
        t_average();
        t_undervolt();
        t_modes();
        // Second reset realigns the three phases for the gradient runs
        arst_n = 1'b0;
        cyc(2);
        t_reset();
        arst_n = 1'b1;
        cyc(300);
        // Falling period means rising frequency
        t_gradient(1'b1);
        t_gradient(1'b0);
        complete_run();
    end

    // Hang guard: counts as a mismatch
    initial
    begin
        #2ms;
        mismatches++;
        complete_run();
    end
endmodule
